// *** design/slcfs_map.vh ***
// register map, field layout, reset values and sizes of the lane crossbar block
`ifndef SLCFS_MAP_VH
`define SLCFS_MAP_VH

// lanes and word sizes
`define SLCFS_LANES 8
`define SLCFS_SEL_W 3
`define SLCFS_DATA_W 8
`define SLCFS_FIFO_DEPTH 8
`define SLCFS_FIFO_AW 3
`define SLCFS_ADDR_W 12

// printed offsets kept as register indices; byte address is four times the index
`define SLCFS_IDX_SEL01 10'h308
`define SLCFS_IDX_SEL23 10'h309
`define SLCFS_IDX_SEL45 10'h30A
`define SLCFS_IDX_SEL67 10'h30B
`define SLCFS_IDX_FULL 10'h30C
`define SLCFS_IDX_EMPTY 10'h30D
`define SLCFS_IDX_SYNC 10'h312
`define SLCFS_IDX_IRQ_STAT 10'h320
`define SLCFS_IDX_IRQ_CLR 10'h321
`define SLCFS_IDX_IRQ_EN 10'h322

// select pair field positions
`define SLCFS_EVEN_LO 0
`define SLCFS_ODD_LO 3
`define SLCFS_PAIR_RSVD 2'h0

// reset values: logical lane n selects physical lane n
`define SLCFS_SEL_RST 24'hFAC688
`define SLCFS_SYNC_RST 8'h00
`define SLCFS_IRQ_RST 16'h0000

// axi responses
`define SLCFS_RESP_OKAY 2'h0
`define SLCFS_RESP_SLVERR 2'h2

`endif

// *** design/slcfs_lane_mux.v ***
// one crossbar leg: picks one physical lane for a logical lane
`timescale 1ns/1ps
`default_nettype none
`include "slcfs_map.vh"

module slcfs_lane_mux (
    // all physical lanes
    input wire [`SLCFS_LANES*`SLCFS_DATA_W-1:0] phys_data,
    input wire [`SLCFS_LANES-1:0] phys_valid,
    // source select
    input wire [`SLCFS_SEL_W-1:0] source_select,
    // chosen lane
    output wire [`SLCFS_DATA_W-1:0] pick_data,
    output wire pick_valid
);

    // any of the eight lanes may feed this leg
    assign pick_data = phys_data[source_select*`SLCFS_DATA_W +: `SLCFS_DATA_W];
    assign pick_valid = phys_valid[source_select];

endmodule
`default_nettype wire

// *** design/slcfs_lane_fifo.v ***
// per logical lane fifo with registered read data and flags
`timescale 1ns/1ps
`default_nettype none
`include "slcfs_map.vh"

module slcfs_lane_fifo (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // fill side
    input wire wr_en,
    input wire [`SLCFS_DATA_W-1:0] wr_data,
    // drain side
    input wire rd_en,
    output reg [`SLCFS_DATA_W-1:0] rd_data_r,
    output reg rd_valid_r,
    // present state
    output reg full_r,
    output reg empty_r
);

    reg [`SLCFS_DATA_W-1:0] mem [0:`SLCFS_FIFO_DEPTH-1];
    reg [`SLCFS_FIFO_AW-1:0] wptr_r;
    reg [`SLCFS_FIFO_AW-1:0] rptr_r;
    reg [`SLCFS_FIFO_AW:0] count_r;
    reg [`SLCFS_FIFO_AW:0] count_nxt;
    wire do_wr;
    wire do_rd;

    // writes into a full fifo are dropped, the full flag tells software
    assign do_wr = wr_en && !full_r;
    assign do_rd = rd_en && !empty_r;

    // occupancy after this edge
    always @* begin
        count_nxt = count_r;
        if (do_wr && !do_rd) begin
            count_nxt = count_r + 1'b1;
        end else if (do_rd && !do_wr) begin
            count_nxt = count_r - 1'b1;
        end
    end

    // storage has no reset; pointers, count, flags and read register do
    always @(posedge aclk) begin
        if (do_wr) begin
            mem[wptr_r] <= wr_data;
        end
    end

    // pointers, flags and read register
    always @(posedge aclk) begin
        if (!aresetn) begin
            wptr_r <= {`SLCFS_FIFO_AW{1'b0}};
            rptr_r <= {`SLCFS_FIFO_AW{1'b0}};
            count_r <= {(`SLCFS_FIFO_AW+1){1'b0}};
            full_r <= 1'b0;
            empty_r <= 1'b1;
            rd_data_r <= {`SLCFS_DATA_W{1'b0}};
            rd_valid_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            // flags track occupancy, never latched
            full_r <= (count_nxt == `SLCFS_FIFO_DEPTH);
            empty_r <= (count_nxt == {(`SLCFS_FIFO_AW+1){1'b0}});
            rd_valid_r <= do_rd;
            if (do_wr) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (do_rd) begin
                rd_data_r <= mem[rptr_r];
                rptr_r <= rptr_r + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// *** design/slcfs_top.v ***
// lane crossbar, lane fifos and their status behind an axi4-lite slave
// Functional notes
// - each logical lane reads its selected physical lane
// - two selects per byte, bits 7:6 zero
// - reset maps logical lane n to physical n
// - read-only full flag per logical lane
// - read-only empty flag per logical lane
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "slcfs_map.vh"

module slcfs_top (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [`SLCFS_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [`SLCFS_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // physical serial input lanes, already deserialised
    input wire [`SLCFS_LANES*`SLCFS_DATA_W-1:0] physical_serial_input,
    input wire [`SLCFS_LANES-1:0] physical_serial_valid,
    // logical lane outputs
    input wire [`SLCFS_LANES-1:0] lane_read,
    output wire [`SLCFS_LANES*`SLCFS_DATA_W-1:0] lane_data,
    output wire [`SLCFS_LANES-1:0] lane_data_valid,
    // sync request setup byte for the sync generator
    output wire [7:0] sync_request_setup,
    // interrupt
    output reg irq
);

    // source selects, three bits per logical lane
    reg [`SLCFS_LANES*`SLCFS_SEL_W-1:0] sel_r;
    reg [7:0] sync_r;
    reg [15:0] irq_stat_r;
    reg [15:0] irq_en_r;
    reg [15:0] irq_stat_nxt;
    reg [15:0] irq_clr;
    reg [`SLCFS_LANES-1:0] full_prev_r;
    reg [`SLCFS_LANES-1:0] empty_prev_r;
    wire [`SLCFS_LANES-1:0] full_w;
    wire [`SLCFS_LANES-1:0] empty_w;
    wire [15:0] irq_event;

    // write channel holding state
    reg aw_hold_r;
    reg w_hold_r;
    reg [9:0] aw_idx_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    wire wr_go;
    wire [9:0] ar_idx;
    reg [31:0] rd_word;
    reg rd_hit;

    wire [`SLCFS_SEL_W-1:0] lane_zero_source_select;
    wire [`SLCFS_SEL_W-1:0] lane_one_source_select;
    wire [`SLCFS_SEL_W-1:0] lane_two_source_select;
    wire [`SLCFS_SEL_W-1:0] lane_three_source_select;
    wire [`SLCFS_SEL_W-1:0] lane_four_source_select;
    wire [`SLCFS_SEL_W-1:0] lane_five_source_select;
    wire [`SLCFS_SEL_W-1:0] lane_six_source_select;
    wire [`SLCFS_SEL_W-1:0] lane_seven_source_select;

    // named views of the select fields
    assign lane_zero_source_select = sel_r[2:0];
    assign lane_one_source_select = sel_r[5:3];
    assign lane_two_source_select = sel_r[8:6];
    assign lane_three_source_select = sel_r[11:9];
    assign lane_four_source_select = sel_r[14:12];
    assign lane_five_source_select = sel_r[17:15];
    assign lane_six_source_select = sel_r[20:18];
    assign lane_seven_source_select = sel_r[23:21];

    assign sync_request_setup = sync_r;

    // one crossbar leg and one fifo per logical lane
    genvar g;
    generate
        for (g = 0; g < `SLCFS_LANES; g = g + 1) begin : g_lane
            wire [`SLCFS_DATA_W-1:0] pick_data;
            wire pick_valid;

            slcfs_lane_mux u_mux (
                .phys_data(physical_serial_input),
                .phys_valid(physical_serial_valid),
                .source_select(sel_r[g*`SLCFS_SEL_W +: `SLCFS_SEL_W]),
                .pick_data(pick_data),
                .pick_valid(pick_valid)
            );

            slcfs_lane_fifo u_fifo (
                .aclk(aclk),
                .aresetn(aresetn),
                .wr_en(pick_valid),
                .wr_data(pick_data),
                .rd_en(lane_read[g]),
                .rd_data_r(lane_data[g*`SLCFS_DATA_W +: `SLCFS_DATA_W]),
                .rd_valid_r(lane_data_valid[g]),
                .full_r(full_w[g]),
                .empty_r(empty_w[g])
            );
        end
    endgenerate

    // write happens once address and data are both held
    assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign ar_idx = s_axi_araddr[11:2];

    // address and data are taken independently, in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_idx_r <= 10'h000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_hold_r <= 1'b1;
                aw_idx_r <= s_axi_awaddr[11:2];
            end else if (wr_go) begin
                aw_hold_r <= 1'b0;
            end else if (!aw_hold_r && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (wr_go) begin
                w_hold_r <= 1'b0;
            end else if (!w_hold_r && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // write response, slverr for addresses nobody owns
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SLCFS_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            case (aw_idx_r)
                `SLCFS_IDX_SEL01, `SLCFS_IDX_SEL23, `SLCFS_IDX_SEL45, `SLCFS_IDX_SEL67,
                `SLCFS_IDX_FULL, `SLCFS_IDX_EMPTY, `SLCFS_IDX_SYNC,
                `SLCFS_IDX_IRQ_STAT, `SLCFS_IDX_IRQ_CLR, `SLCFS_IDX_IRQ_EN: begin
                    s_axi_bresp <= `SLCFS_RESP_OKAY;
                end
                default: begin
                    s_axi_bresp <= `SLCFS_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // software registers; flag registers are read-only, writes ignored
    always @(posedge aclk) begin
        if (!aresetn) begin
            sel_r <= `SLCFS_SEL_RST;
            sync_r <= `SLCFS_SYNC_RST;
            irq_en_r <= `SLCFS_IRQ_RST;
        end else if (wr_go) begin
            case (aw_idx_r)
                `SLCFS_IDX_SEL01: begin
                    if (wstrb_r[0]) begin
                        sel_r[5:0] <= wdata_r[5:0];
                    end
                end
                `SLCFS_IDX_SEL23: begin
                    if (wstrb_r[0]) begin
                        sel_r[11:6] <= wdata_r[5:0];
                    end
                end
                `SLCFS_IDX_SEL45: begin
                    if (wstrb_r[0]) begin
                        sel_r[17:12] <= wdata_r[5:0];
                    end
                end
                `SLCFS_IDX_SEL67: begin
                    if (wstrb_r[0]) begin
                        sel_r[23:18] <= wdata_r[5:0];
                    end
                end
                `SLCFS_IDX_SYNC: begin
                    if (wstrb_r[0]) begin
                        sync_r <= wdata_r[7:0];
                    end
                end
                `SLCFS_IDX_IRQ_EN: begin
                    if (wstrb_r[0]) begin
                        irq_en_r[7:0] <= wdata_r[7:0];
                    end
                    if (wstrb_r[1]) begin
                        irq_en_r[15:8] <= wdata_r[15:8];
                    end
                end
                default: begin
                    sync_r <= sync_r;
                end
            endcase
        end
    end

    // onset of full or empty on any lane raises an event
    assign irq_event = {empty_w & ~empty_prev_r, full_w & ~full_prev_r};

    // clear bits written this cycle, per byte lane
    always @* begin
        irq_clr = 16'h0000;
        if (wr_go && aw_idx_r == `SLCFS_IDX_IRQ_CLR) begin
            irq_clr = {{8{wstrb_r[1]}} & wdata_r[15:8], {8{wstrb_r[0]}} & wdata_r[7:0]};
        end
        // a new event beats a clear in the same cycle
        irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_event;
    end

    // sticky status and level interrupt
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= `SLCFS_IRQ_RST;
            full_prev_r <= {`SLCFS_LANES{1'b0}};
            empty_prev_r <= {`SLCFS_LANES{1'b1}};
            irq <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            full_prev_r <= full_w;
            empty_prev_r <= empty_w;
            irq <= |(irq_stat_nxt & irq_en_r);
        end
    end

    // read decode; flags come straight from the fifos, untouched by reads
    always @* begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        case (ar_idx)
            `SLCFS_IDX_SEL01: rd_word[7:0] = {`SLCFS_PAIR_RSVD, sel_r[5:0]};
            `SLCFS_IDX_SEL23: rd_word[7:0] = {`SLCFS_PAIR_RSVD, sel_r[11:6]};
            `SLCFS_IDX_SEL45: rd_word[7:0] = {`SLCFS_PAIR_RSVD, sel_r[17:12]};
            `SLCFS_IDX_SEL67: rd_word[7:0] = {`SLCFS_PAIR_RSVD, sel_r[23:18]};
            `SLCFS_IDX_FULL: rd_word[7:0] = full_w;
            `SLCFS_IDX_EMPTY: rd_word[7:0] = empty_w;
            `SLCFS_IDX_SYNC: rd_word[7:0] = sync_r;
            `SLCFS_IDX_IRQ_STAT: rd_word[15:0] = irq_stat_r;
            `SLCFS_IDX_IRQ_EN: rd_word[15:0] = irq_en_r;
            `SLCFS_IDX_IRQ_CLR: rd_word = 32'h00000000;
            default: rd_hit = 1'b0;
        endcase
    end

    // read channel: one read in flight, answer one edge after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SLCFS_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `SLCFS_RESP_OKAY : `SLCFS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// *** test/slcfs_tx_model.sv ***
// far-end lane transmitter model driving the eight deserialised physical lanes
`timescale 1ns/1ps
`default_nettype none
module slcfs_tx_model (
    // clock
    input wire logic aclk,
    // lanes toward the receiver
    output logic [63:0] phys_data,
    output logic [7:0] phys_valid
);
    initial begin
        phys_data = 64'h0;
        phys_valid = 8'h00;
    end
    // word on lane p at step k is {p, k}, so the bench can tell source and order apart
    task automatic send(input logic [7:0] mask, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge aclk);
            phys_valid <= mask;
            for (int p = 0; p < 8; p++) phys_data[p*8+:8] <= {p[2:0], k[4:0]};
        end
        @(posedge aclk);
        phys_valid <= 8'h00;
        // idle lanes show the inverse so a stale word never passes for a fresh one
        phys_data <= ~phys_data;
    endtask
endmodule
`default_nettype wire

// *** test/slcfs_top_monitor.sv ***
// assertion checker on the lane crossbar top ports
`timescale 1ns/1ps
`default_nettype none
module slcfs_top_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // logical lanes and interrupt
    input wire logic [7:0] lane_read,
    input wire logic [63:0] lane_data,
    input wire logic [7:0] lane_data_valid,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // answers stand until taken; a dropped one loses the transfer
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    a_aw_drops: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready stayed high");
    a_b_after_both: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
        else $error("response before address and data");
    // no register is wider than 16 bits
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    // lane outputs move only after a pop
    a_pop_only: assert property ((lane_data_valid & ~$past(lane_read)) == 8'h00)
        else $error("lane valid without pop");
    a_data_held: assert property (!$stable(lane_data) |-> $past(lane_read) != 8'h00)
        else $error("lane data moved without pop");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_pop: cover property (lane_data_valid != 8'h00);
    c_irq: cover property (irq);
endmodule
bind slcfs_top slcfs_top_monitor i_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .lane_read, .lane_data, .lane_data_valid, .irq);
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the lane crossbar: registers, data path and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "slcfs_map.vh"
module tb_top;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic [7:0] lane_read;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [63:0] physical_serial_input, lane_data;
    wire [7:0] physical_serial_valid, lane_data_valid, sync_request_setup;
    int mismatches = 0;
    int n_compared = 0;
    // late ready: wait for the answer first, so the slave must hold it
    logic slow = 1'b0;
    localparam logic [11:0] ad_sel = {`SLCFS_IDX_SEL01, 2'b00};
    localparam logic [11:0] ad_full = {`SLCFS_IDX_FULL, 2'b00};
    localparam logic [11:0] ad_empty = {`SLCFS_IDX_EMPTY, 2'b00};
    localparam logic [11:0] ad_sync = {`SLCFS_IDX_SYNC, 2'b00};
    localparam logic [11:0] ad_stat = {`SLCFS_IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] ad_clr = {`SLCFS_IDX_IRQ_CLR, 2'b00};
    localparam logic [11:0] ad_en = {`SLCFS_IDX_IRQ_EN, 2'b00};
    localparam logic [1:0] ok = `SLCFS_RESP_OKAY;
    localparam logic [1:0] err = `SLCFS_RESP_SLVERR;
    slcfs_tx_model i_tx (.aclk, .phys_data(physical_serial_input), .phys_valid(physical_serial_valid));
    slcfs_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .physical_serial_input,
        .physical_serial_valid, .lane_read, .lane_data, .lane_data_valid, .sync_request_setup, .irq);
    // 125 mhz clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic da, dw;
        da = 1'b0;
        dw = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !slow;
        while (!(da && dw)) begin
            @(posedge aclk);
            if (!da && s_axi_awready) begin
                da = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!dw && s_axi_wready) begin
                dw = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        if (slow) begin
            do @(posedge aclk); while (!s_axi_bvalid);
            s_axi_bready <= 1'b1;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !slow;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        if (slow) begin
            do @(posedge aclk); while (!s_axi_rvalid);
            s_axi_rready <= 1'b1;
        end
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
    endtask
    // one-cycle pop, looked at mid-cycle after the pulse lands
    task automatic pop(input int x, input logic [7:0] e, input logic v);
        @(posedge aclk);
        lane_read <= 8'h01 << x;
        @(posedge aclk);
        lane_read <= 8'h00;
        @(negedge aclk);
        chk(lane_data_valid[x], v);
        chk(lane_data[x*8+:8], e);
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hF;
        lane_read = 8'h00;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd(12'(ad_sel + 4 * i), 32'((2 * i + 1) * 8 + 2 * i), ok);
        rd(ad_full, 32'h0, ok);
        rd(ad_empty, 32'hFF, ok);
        rd(ad_sync, 32'h0, ok);
        $display("test reset_values done");
        i_tx.send(8'hFF, 3);
        for (int x = 0; x < 8; x++) for (int k = 0; k < 3; k++) pop(x, {x[2:0], k[4:0]}, 1'b1);
        rd(ad_empty, 32'hFF, ok);
        $display("test identity_path done");
        // reverse map with the reserved bits set in every write
        slow = 1'b1;
        for (int i = 0; i < 4; i++) wr(12'(ad_sel + 4 * i), 32'(8'hC0 | ((6 - 2 * i) * 8 + 7 - 2 * i)), ok);
        for (int i = 0; i < 4; i++) rd(12'(ad_sel + 4 * i), 32'((6 - 2 * i) * 8 + 7 - 2 * i), ok);
        // low byte strobe off: the select pair must not move
        s_axi_wstrb <= 4'hE;
        wr(ad_sel, 32'h3F, ok);
        s_axi_wstrb <= 4'hF;
        rd(ad_sel, 32'h37, ok);
        wr(ad_sync, 32'hA5, ok);
        @(negedge aclk);
        chk(sync_request_setup, 32'hA5);
        wr(ad_full, 32'hFF, ok);
        rd(ad_full, 32'h0, ok);
        wr(12'hC38, 32'h1, err);
        rd(12'hC38, 32'h0, err);
        i_tx.send(8'hFF, 2);
        for (int x = 0; x < 8; x++) for (int k = 0; k < 2; k++) pop(x, {3'(7 - x), k[4:0]}, 1'b1);
        $display("test remap done");
        slow = 1'b0;
        // overfill logical 7 from physical 0, interrupt on its empty onset
        wr(ad_clr, 32'hFFFF, ok);
        wr(ad_en, 32'h8000, ok);
        i_tx.send(8'h01, 10);
        rd(ad_full, 32'h80, ok);
        rd(ad_empty, 32'h7F, ok);
        rd(ad_full, 32'h80, ok);
        @(negedge aclk);
        chk(irq, 1'b0);
        for (int k = 0; k < 8; k++) pop(7, {3'h0, k[4:0]}, 1'b1);
        pop(7, 8'h07, 1'b0);
        rd(ad_full, 32'h0, ok);
        rd(ad_empty, 32'hFF, ok);
        rd(ad_stat, 32'h8080, ok);
        @(negedge aclk);
        chk(irq, 1'b1);
        wr(ad_en, 32'h0, ok);
        @(negedge aclk);
        chk(irq, 1'b0);
        wr(ad_en, 32'h8000, ok);
        wr(ad_clr, 32'h8000, ok);
        @(negedge aclk);
        chk(irq, 1'b0);
        rd(ad_stat, 32'h0080, ok);
        $display("test overflow_irq done");
        complete_run;
    end
    // hang guard, far beyond the few hundred cycles the tests take
    initial begin
        #200000;
        mismatches++;
        complete_run;
    end
endmodule
`default_nettype wire
